// [logic/ana_regs.sv]
// Auto-negotiation local advertisement and partner ability registers.
// Assumes the management port and negotiation engine share CLK.
//
// Behaviour
// - Advert register feeds outgoing codeword abilities
// - Advert next-page bit reads zero always
// - Engine drives acknowledge bit, read-only, resets zero
// - Advert bit 13 local fault, RW, reset 0
// - Advert bits 12:11 reserved RW, meaningless
// - Advert bit 10 pause ability RW, reset 0
// - Advert bit 9 T4 reads zero always
// - Advert bits 8:5 RW, reset ones
// - Advert selector RW, reset 00001
// - Partner register read-only, loaded from codewords
// - Partner bit 15 partner next page
// - Partner bit 14 partner acknowledge from codeword
// - Partner bit 13 partner remote fault
// - Partner bits 12:11 read zero
// - Partner bit 10 partner pause ability
// - Partner bits 9:5 partner technology abilities
// - Partner selector resets 00000
// - Partner fault sets latched status fault
`include "ana_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ana_regs (
    input  wire logic             CLK,
    input  wire logic             SYS_RST,
    input  wire ana_pkg::ana_addr_t MGMT_ADDR,
    input  wire logic             MGMT_WR,
    input  wire logic             MGMT_RD,
    input  wire ana_pkg::ana_word_t MGMT_WDATA,
    output var  ana_pkg::ana_word_t MGMT_RDATA,
    output var  logic             MGMT_RVALID,
    input  wire logic             AN_ACK_TX,
    input  wire logic             AN_CW_VALID,
    input  wire ana_pkg::ana_word_t AN_CW_RX,
    input  wire logic             AN_CLEAR,
    output var  ana_pkg::ana_word_t LOCAL_ABILITY_ADVERT,
    output var  logic             PARTNER_FAULT_EVENT
);
    import ana_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic ana_sel_e decode(input ana_addr_t a);
        case (a)
            `ANA_ADDR_ADVERT:  decode = ANA_SEL_ADVERT;
            `ANA_ADDR_PARTNER: decode = ANA_SEL_PARTNER;
            default:           decode = ANA_SEL_NONE;
        endcase
    endfunction : decode

    // ------------------------------------------------------------
    // Field helpers
    // ------------------------------------------------------------
    // One bit of a word; reset values, write data and codewords share it
    function automatic logic bit_of(input ana_word_t w, input int unsigned i);
        bit_of = w[i];
    endfunction : bit_of

    // Protocol selector field of a word
    function automatic logic [4:0] sel_of(input ana_word_t w);
        sel_of = w[`ANA_SEL_HI:`ANA_SEL_LO];
    endfunction : sel_of

    // Technology field of a word, T4 down to slow half duplex
    function automatic logic [4:0] tech_of(input ana_word_t w);
        tech_of = w[`ANA_BIT_T4:`ANA_BIT_SLOW_HDX];
    endfunction : tech_of

    // ------------------------------------------------------------
    // Storage and views
    // ------------------------------------------------------------
    ana_sel_e   sel;
    logic       adv_wr;
    // Advertised fields
    logic       fault_q;
    logic [1:0] rsv_q;
    logic       pause_q;
    logic       fast_fdx_q;
    logic       fast_hdx_q;
    logic       slow_fdx_q;
    logic       slow_hdx_q;
    logic [4:0] selector_q;
    logic       ack_q;
    ana_word_t  advert_view;
    // Partner fields
    logic       lp_load;
    logic       lp_clear;
    logic       lp_next_page_q;
    logic       lp_ack_q;
    logic       lp_fault_q;
    logic       lp_pause_q;
    logic [4:0] lp_tech_q;
    logic [4:0] lp_sel_q;
    ana_word_t  partner_view;

    assign sel = decode(MGMT_ADDR);
    // Writes to address 5 or unmapped addresses reach no storage at all
    assign adv_wr   = MGMT_WR && (sel == ANA_SEL_ADVERT);
    // Clear outranks a codeword landing in the same cycle
    assign lp_clear = AN_CLEAR;
    assign lp_load  = AN_CW_VALID && !AN_CLEAR;

    // ------------------------------------------------------------
    // Local advertisement
    // ------------------------------------------------------------
    // ------------------------------------------------------------
    // Advertised fields
    // ------------------------------------------------------------
    // Only writable fields and the engine ack have storage; next page and T4 have none,
    // so no write can ever make them read as one
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            fault_q <= bit_of(`ANA_ADVERT_RESET, `ANA_BIT_FAULT);
        end else if (adv_wr) begin
            fault_q <= bit_of(MGMT_WDATA, `ANA_BIT_FAULT);
        end
    end

    // Reserved pair is stored as written; software is meant to keep it zero
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rsv_q <= 2'b00;
        end else if (adv_wr) begin
            rsv_q <= MGMT_WDATA[`ANA_BIT_RSV_HI:`ANA_BIT_RSV_LO];
        end
    end

    // Pause ability starts off; software opts in
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pause_q <= bit_of(`ANA_ADVERT_RESET, `ANA_BIT_PAUSE);
        end else if (adv_wr) begin
            pause_q <= bit_of(MGMT_WDATA, `ANA_BIT_PAUSE);
        end
    end

    // Technology abilities; reset advertises all four
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            fast_fdx_q <= bit_of(`ANA_ADVERT_RESET, `ANA_BIT_FAST_FDX);
        end else if (adv_wr) begin
            fast_fdx_q <= bit_of(MGMT_WDATA, `ANA_BIT_FAST_FDX);
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            fast_hdx_q <= bit_of(`ANA_ADVERT_RESET, `ANA_BIT_FAST_HDX);
        end else if (adv_wr) begin
            fast_hdx_q <= bit_of(MGMT_WDATA, `ANA_BIT_FAST_HDX);
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            slow_fdx_q <= bit_of(`ANA_ADVERT_RESET, `ANA_BIT_SLOW_FDX);
        end else if (adv_wr) begin
            slow_fdx_q <= bit_of(MGMT_WDATA, `ANA_BIT_SLOW_FDX);
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            slow_hdx_q <= bit_of(`ANA_ADVERT_RESET, `ANA_BIT_SLOW_HDX);
        end else if (adv_wr) begin
            slow_hdx_q <= bit_of(MGMT_WDATA, `ANA_BIT_SLOW_HDX);
        end
    end

    // Selector is not checked; any code written is advertised as is
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            selector_q <= sel_of(`ANA_ADVERT_RESET);
        end else if (adv_wr) begin
            selector_q <= sel_of(MGMT_WDATA);
        end
    end

    // ------------------------------------------------------------
    // Engine acknowledge
    // ------------------------------------------------------------
    // Ack comes only from the engine, so a stray software write cannot corrupt it
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= AN_ACK_TX;
        end
    end

    // ------------------------------------------------------------
    // Advert word assembly
    // ------------------------------------------------------------
    // Fixed zeros are wired here rather than stored
    always_comb begin
        advert_view                                   = '0;
        advert_view[`ANA_BIT_NEXT_PAGE]               = 1'b0;
        advert_view[`ANA_BIT_ACK]                     = ack_q;
        advert_view[`ANA_BIT_FAULT]                   = fault_q;
        advert_view[`ANA_BIT_RSV_HI:`ANA_BIT_RSV_LO]  = rsv_q;
        advert_view[`ANA_BIT_PAUSE]                   = pause_q;
        advert_view[`ANA_BIT_T4]                      = 1'b0;
        advert_view[`ANA_BIT_FAST_FDX]                = fast_fdx_q;
        advert_view[`ANA_BIT_FAST_HDX]                = fast_hdx_q;
        advert_view[`ANA_BIT_SLOW_FDX]                = slow_fdx_q;
        advert_view[`ANA_BIT_SLOW_HDX]                = slow_hdx_q;
        advert_view[`ANA_SEL_HI:`ANA_SEL_LO]          = selector_q;
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            LOCAL_ABILITY_ADVERT <= `ANA_ADVERT_RESET;
        end else begin
            LOCAL_ABILITY_ADVERT <= advert_view;
        end
    end

    // ------------------------------------------------------------
    // Partner ability record
    // ------------------------------------------------------------
    // ------------------------------------------------------------
    // Partner fields
    // ------------------------------------------------------------
    // Writes at address 5 are dropped; reserved bits have no storage,
    // so a noisy codeword cannot make them read as one
    // Partner next page
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lp_next_page_q <= bit_of(`ANA_PARTNER_RESET, `ANA_BIT_NEXT_PAGE);
        end else if (lp_clear) begin
            lp_next_page_q <= bit_of(`ANA_PARTNER_RESET, `ANA_BIT_NEXT_PAGE);
        end else if (lp_load) begin
            lp_next_page_q <= bit_of(AN_CW_RX, `ANA_BIT_NEXT_PAGE);
        end
    end

    // Partner acknowledge, taken from the received codeword
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lp_ack_q <= bit_of(`ANA_PARTNER_RESET, `ANA_BIT_ACK);
        end else if (lp_clear) begin
            lp_ack_q <= bit_of(`ANA_PARTNER_RESET, `ANA_BIT_ACK);
        end else if (lp_load) begin
            lp_ack_q <= bit_of(AN_CW_RX, `ANA_BIT_ACK);
        end
    end

    // Partner remote fault
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lp_fault_q <= bit_of(`ANA_PARTNER_RESET, `ANA_BIT_FAULT);
        end else if (lp_clear) begin
            lp_fault_q <= bit_of(`ANA_PARTNER_RESET, `ANA_BIT_FAULT);
        end else if (lp_load) begin
            lp_fault_q <= bit_of(AN_CW_RX, `ANA_BIT_FAULT);
        end
    end

    // Partner pause ability
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lp_pause_q <= bit_of(`ANA_PARTNER_RESET, `ANA_BIT_PAUSE);
        end else if (lp_clear) begin
            lp_pause_q <= bit_of(`ANA_PARTNER_RESET, `ANA_BIT_PAUSE);
        end else if (lp_load) begin
            lp_pause_q <= bit_of(AN_CW_RX, `ANA_BIT_PAUSE);
        end
    end

    // Partner technologies, T4 included since the partner may offer it
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lp_tech_q <= tech_of(`ANA_PARTNER_RESET);
        end else if (lp_clear) begin
            lp_tech_q <= tech_of(`ANA_PARTNER_RESET);
        end else if (lp_load) begin
            lp_tech_q <= tech_of(AN_CW_RX);
        end
    end

    // Partner selector
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lp_sel_q <= sel_of(`ANA_PARTNER_RESET);
        end else if (lp_clear) begin
            lp_sel_q <= sel_of(`ANA_PARTNER_RESET);
        end else if (lp_load) begin
            lp_sel_q <= sel_of(AN_CW_RX);
        end
    end

    // ------------------------------------------------------------
    // Partner word assembly
    // ------------------------------------------------------------
    // Read-only view; only codewords and clear change it
    always_comb begin
        partner_view                                  = '0;
        partner_view[`ANA_BIT_NEXT_PAGE]              = lp_next_page_q;
        partner_view[`ANA_BIT_ACK]                    = lp_ack_q;
        partner_view[`ANA_BIT_FAULT]                  = lp_fault_q;
        partner_view[`ANA_BIT_RSV_HI:`ANA_BIT_RSV_LO] = 2'b00;
        partner_view[`ANA_BIT_PAUSE]                  = lp_pause_q;
        partner_view[`ANA_BIT_T4:`ANA_BIT_SLOW_HDX]   = lp_tech_q;
        partner_view[`ANA_SEL_HI:`ANA_SEL_LO]         = lp_sel_q;
    end

    // One-cycle pulse for the latched status fault bit elsewhere
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PARTNER_FAULT_EVENT <= 1'b0;
        end else begin
            PARTNER_FAULT_EVENT <= AN_CW_VALID && !AN_CLEAR
                                   && AN_CW_RX[`ANA_BIT_FAULT];
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MGMT_RDATA  <= '0;
            MGMT_RVALID <= 1'b0;
        end else begin
            MGMT_RVALID <= MGMT_RD;
            if (MGMT_RD) begin
                case (sel)
                    ANA_SEL_ADVERT:  MGMT_RDATA <= advert_view;
                    ANA_SEL_PARTNER: MGMT_RDATA <= partner_view;
                    default:         MGMT_RDATA <= '0;
                endcase
            end
        end
    end

endmodule : ana_regs
`default_nettype wire

// [common/ana_cfg.svh]
// Constants for the auto-negotiation ability register bank.
// Assumes a 16-bit PHY management register port with 5-bit register addresses.
`ifndef ANA_CFG_SVH
`define ANA_CFG_SVH

`define ANA_ADDR_W          5
`define ANA_DATA_W          16
`define ANA_ADDR_ADVERT     5'h04
`define ANA_ADDR_PARTNER    5'h05
`define ANA_BIT_NEXT_PAGE   15
`define ANA_BIT_ACK         14
`define ANA_BIT_FAULT       13
`define ANA_BIT_RSV_HI      12
`define ANA_BIT_RSV_LO      11
`define ANA_BIT_PAUSE       10
`define ANA_BIT_T4          9
`define ANA_BIT_FAST_FDX    8
`define ANA_BIT_FAST_HDX    7
`define ANA_BIT_SLOW_FDX    6
`define ANA_BIT_SLOW_HDX    5
`define ANA_SEL_HI          4
`define ANA_SEL_LO          0
`define ANA_ADVERT_RESET    16'h01e1
`define ANA_ADVERT_WMASK    16'h3dff
`define ANA_PARTNER_MASK    16'he7ff
`define ANA_PARTNER_RESET   16'h0000

`endif

// [common/ana_pkg.sv]
// Types shared by the auto-negotiation ability register bank.
// Assumes ana_cfg.svh supplies widths.
`include "ana_cfg.svh"

package ana_pkg;
    typedef logic [`ANA_DATA_W-1:0] ana_word_t;
    typedef logic [`ANA_ADDR_W-1:0] ana_addr_t;
    typedef enum logic [1:0] {
        ANA_SEL_NONE    = 2'b00,
        ANA_SEL_ADVERT  = 2'b01,
        ANA_SEL_PARTNER = 2'b10
    } ana_sel_e;
endpackage : ana_pkg

// [tb/ana_regs_asserts.sv]
// Port checker for the ability register bank.
// Assumes it is bound into ana_regs.
`timescale 1ns/1ps
`default_nettype none
module ana_regs_asserts (
    input wire logic CLK, SYS_RST, MGMT_RD, MGMT_WR, MGMT_RVALID,
    input wire logic AN_ACK_TX, AN_CW_VALID, AN_CLEAR, PARTNER_FAULT_EVENT,
    input wire ana_pkg::ana_addr_t MGMT_ADDR,
    input wire ana_pkg::ana_word_t MGMT_WDATA, MGMT_RDATA, AN_CW_RX, LOCAL_ABILITY_ADVERT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // Two idle cycles so a later write cannot mask the first
    sequence s_adv_wr; MGMT_WR && MGMT_ADDR == 5'h04 ##1 !MGMT_WR [*2]; endsequence
    a_read_answer: assert property (MGMT_RD |=> MGMT_RVALID) else $error("no answer");
    a_read_quiet: assert property (!MGMT_RD |=> !MGMT_RVALID && $stable(MGMT_RDATA))
        else $error("spurious answer");
    a_fixed_zero: assert property ((LOCAL_ABILITY_ADVERT & 16'h8200) == 16'h0000)
        else $error("fixed bits set");
    a_ack_shown: assert property (AN_ACK_TX [*3] |-> LOCAL_ABILITY_ADVERT[14])
        else $error("ack missing");
    a_ack_clear: assert property (!AN_ACK_TX [*3] |-> !LOCAL_ABILITY_ADVERT[14])
        else $error("ack stuck");
    a_fault_event: assert property (AN_CW_VALID && !AN_CLEAR |=>
        PARTNER_FAULT_EVENT == $past(AN_CW_RX[13])) else $error("fault event");
    a_fault_quiet: assert property (!AN_CW_VALID || AN_CLEAR |=> !PARTNER_FAULT_EVENT)
        else $error("stray fault");
    a_advert_wr: assert property (s_adv_wr |=> (LOCAL_ABILITY_ADVERT & 16'h25ff) ==
        ($past(MGMT_WDATA, 3) & 16'h25ff)) else $error("advert write");
    a_partner_rsv: assert property (MGMT_RD && MGMT_ADDR == 5'h05 |=>
        (MGMT_RDATA & 16'h1800) == 16'h0000) else $error("reserved set");
endmodule : ana_regs_asserts
bind ana_regs ana_regs_asserts u_chk (.*);
`default_nettype wire

// [tb/ana_lp.sv]
// Link partner model delivering received codewords.
// Assumes it shares the bank's clock.
`timescale 1ns/1ps
`default_nettype none
module ana_lp (
    input  wire logic               CLK,
    output var  logic               VLD,
    output var  ana_pkg::ana_word_t CW
);
    initial begin
        VLD = 1'b0;
        CW = 16'h0000;
    end
    // Inverted after the pulse so stale data is never trusted
    task send(input ana_pkg::ana_word_t w);
        @(posedge CLK) begin VLD <= 1'b1; CW <= w; end
        @(posedge CLK) begin VLD <= 1'b0; CW <= ~w; end
    endtask : send
endmodule : ana_lp
`default_nettype wire

// [tb/autoneg_ability_registers_bench.sv]
// Bench for the ability register bank.
// Assumes ana_regs, ana_lp and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module autoneg_ability_registers_bench;
    import ana_pkg::*;
    logic clk = 0, rst = 1, rd = 0, wr = 0, ack = 0, clr = 0, rvalid, fault, cwv;
    ana_addr_t addr = '0;
    ana_word_t wdata = '0, rdata, adv, cw;
    int fails = 0, num_checks = 0;
    always #5 clk = ~clk;
    ana_regs dut (.CLK(clk), .SYS_RST(rst), .MGMT_ADDR(addr), .MGMT_WR(wr), .MGMT_RD(rd),
        .MGMT_WDATA(wdata), .MGMT_RDATA(rdata), .MGMT_RVALID(rvalid), .AN_ACK_TX(ack),
        .AN_CW_VALID(cwv), .AN_CW_RX(cw), .AN_CLEAR(clr), .LOCAL_ABILITY_ADVERT(adv),
        .PARTNER_FAULT_EVENT(fault));
    ana_lp lp (.CLK(clk), .VLD(cwv), .CW(cw));
    task chk(input ana_word_t got, exp);
        num_checks++;
        if (got !== exp) begin fails++; $display("BAD %0t %h %h", $time, got, exp); end
    endtask : chk
    task wrr(input ana_addr_t a, input ana_word_t d);
        @(posedge clk) begin wr <= 1; addr <= a; wdata <= d; end
        @(posedge clk) wr <= 0;
    endtask : wrr
    // Bits 12:11 of the advert are masked: their read value has no meaning
    task rdc(input ana_addr_t a, input ana_word_t m, e);
        @(posedge clk) begin rd <= 1; addr <= a; end
        @(posedge clk) rd <= 0;
        #1 chk({15'h0000, rvalid}, 16'h0001);
        chk(rdata & m, e);
    endtask : rdc
    task results;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        rdc(5'h04, 16'he7ff, 16'h01e1);
        rdc(5'h05, 16'hffff, 16'h0000);
        wrr(5'h04, 16'ha7ff);
        rdc(5'h04, 16'he7ff, 16'h25ff);
        chk(adv & 16'he7ff, 16'h25ff);
        wrr(5'h04, 16'h0000);
        rdc(5'h04, 16'he7ff, 16'h0000);
        wrr(5'h05, 16'hbfff);
        rdc(5'h05, 16'hffff, 16'h0000);
        rdc(5'h06, 16'hffff, 16'h0000);
        @(posedge clk) ack <= 1;
        repeat (3) @(posedge clk);
        rdc(5'h04, 16'h4000, 16'h4000);
        @(posedge clk) ack <= 0;
        lp.send(16'hffff);
        #1 chk({15'h0000, fault}, 16'h0001);
        rdc(5'h05, 16'hffff, 16'he7ff);
        lp.send(16'h8421);
        #1 chk({15'h0000, fault}, 16'h0000);
        rdc(5'h05, 16'hffff, 16'h8421);
        @(posedge clk) clr <= 1;
        @(posedge clk) clr <= 0;
        rdc(5'h05, 16'hffff, 16'h0000);
        results;
    end
endmodule : autoneg_ability_registers_bench
`default_nettype wire
